// ===== pkg/adcs_pkg.sv
// Contract
// - Time code selects 144..48 main-clock periods.
// - Edge field selects none, fall, rise, both.
// - Channel select at ff81, reset 00, two bits.
// - Bit 7 tried first against half reference.
// - Lower bits tried in turn, kept if input >= tap.
// - After 8 bits, result latched and irq raised.
// - Sampling lasts 20,16,12,10,8,6 periods.
// - Start delay half cpu clock plus 6-8 or 3-4.
// - Conversions repeat until enable bit cleared.
// - Reset clears result register.
// - Hardware start waits for valid trigger edge.
// - Hardware start idles after each result.
// - Channel write aborts hardware conversion, waits.
// - Enable rewrite aborts, waits next trigger.
// - Enable cleared halts conversion at once.
// - Software start converts back to back.
// - Channel write restarts software conversion.
// - Enable rewrite restarts software conversion.
// - Standby stops all conversion activity.
// - Mode register ff80, reset 00, field layout.
// - Register write beats end of conversion.
// - Result read completes before new result lands.
// - Trigger edges ignored during conversion.
package adcs_pkg;
  localparam logic [15:0] ADDR_MODE = 16'hff80;
  localparam logic [15:0] ADDR_CHAN = 16'hff81;
  localparam logic [15:0] ADDR_RESULT = 16'hff1f;
  localparam logic [15:0] ADDR_FLAG = 16'hff82;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam int EN_BIT = 7;
  localparam int HW_BIT = 6;
  localparam int TIME_LSB = 3;
  localparam int EDGE_LSB = 1;
  localparam int CNT_W = 8;
  localparam int CMP_CYCLES = 2;
  localparam int DLY_LONG = 7;
  localparam int DLY_SHORT = 4;
  localparam int CPU_HALF = 1;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_SAMPLE, ST_CONV} adcs_state_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } adcs_bus_t;

  typedef struct packed {
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] sample;
    logic [CNT_W-1:0] delay;
    logic legal;
  } adcs_timing_t;

  function automatic adcs_timing_t adcs_timing(input logic [2:0] code);
    adcs_timing_t t;
    t = '{total: 8'd144, sample: 8'd20, delay: 8'(CPU_HALF + DLY_LONG), legal: 1'b1};
    unique case (code)
      3'h0: t = '{total: 8'd144, sample: 8'd20, delay: 8'(CPU_HALF + DLY_LONG), legal: 1'b1};
      3'h1: t = '{total: 8'd120, sample: 8'd16, delay: 8'(CPU_HALF + DLY_LONG), legal: 1'b1};
      3'h2: t = '{total: 8'd96, sample: 8'd12, delay: 8'(CPU_HALF + DLY_LONG), legal: 1'b1};
      3'h4: t = '{total: 8'd72, sample: 8'd10, delay: 8'(CPU_HALF + DLY_SHORT), legal: 1'b1};
      3'h5: t = '{total: 8'd60, sample: 8'd8, delay: 8'(CPU_HALF + DLY_SHORT), legal: 1'b1};
      3'h6: t = '{total: 8'd48, sample: 8'd6, delay: 8'(CPU_HALF + DLY_SHORT), legal: 1'b1};
      default: t.legal = 1'b0;
    endcase
    return t;
  endfunction : adcs_timing
endpackage : adcs_pkg

// ===== rtl/adcs_edge.sv
`timescale 1ns/1ps
module adcs_edge
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire logic [1:0] sel,
  output logic hit
);
  typedef struct packed {
    logic [2:0] sync;
  } adcs_edge_st_t;
  adcs_edge_st_t s_q, s_d;
  logic rise;
  logic fall;
  // Sync stage two and three feed the detector; stage one only feeds stage two
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], pin};
    rise = s_q.sync[1] & ~s_q.sync[2];
    fall = ~s_q.sync[1] & s_q.sync[2];
    hit = (sel[0] & fall) | (sel[1] & rise);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : adcs_edge

// ===== rtl/adcs_sequencer.sv
`timescale 1ns/1ps
module adcs_sequencer
  import adcs_pkg::*;
(
  CLK_SYS,
  ARST_N,
  BUS_WE,
  BUS_RE,
  BUS_ADDR,
  BUS_WDATA,
  BUS_RDATA,
  FLAG_CLR,
  STANDBY,
  TRIGGER_PIN,
  CMP_GE,
  TAP_CODE,
  CHANNEL_SEL,
  SAMPLE_EN,
  CONV_BUSY,
  CONV_END_IRQ,
  CONV_END_FLAG
);
  input wire logic CLK_SYS;
  input wire logic ARST_N;
  input wire logic BUS_WE;
  input wire logic BUS_RE;
  input wire logic [15:0] BUS_ADDR;
  input wire logic [7:0] BUS_WDATA;
  output logic [7:0] BUS_RDATA;
  input wire logic FLAG_CLR;
  input wire logic STANDBY;
  input wire logic TRIGGER_PIN;
  input wire logic CMP_GE;
  output logic [7:0] TAP_CODE;
  output logic [1:0] CHANNEL_SEL;
  output logic SAMPLE_EN;
  output logic CONV_BUSY;
  output logic CONV_END_IRQ;
  output logic CONV_END_FLAG;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    adcs_state_t st;
    logic [7:0] mode;
    logic [7:0] chan;
    logic [7:0] result;
    logic [7:0] successive_approx_reg;
    logic [2:0] bitn;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] step;
    logic flag;
    logic irq;
    logic [7:0] rdata;
    logic [2:0] cmp_sync;
    logic smp_en;
    logic conv_on;
  } adcs_seq_st_t;

  adcs_seq_st_t s_q, s_d;
  adcs_bus_t bus;
  adcs_timing_t tm;
  adcs_timing_t tm_nx;
  logic trig_hit;
  logic wr_mode;
  logic wr_chan;
  logic en;
  logic hw;
  logic cmp;
  logic busy;
  logic done;

  assign bus = '{we: BUS_WE, re: BUS_RE, addr: BUS_ADDR, wdata: BUS_WDATA};

  adcs_edge u_edge (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .pin(TRIGGER_PIN),
    .sel(s_q.mode[EDGE_LSB +: 2]),
    .hit(trig_hit)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.cmp_sync = {s_q.cmp_sync[1:0], CMP_GE};
    cmp = s_q.cmp_sync[2];
    tm = adcs_timing(s_q.mode[TIME_LSB +: 3]);
    wr_mode = bus.we && bus.addr == ADDR_MODE;
    wr_chan = bus.we && bus.addr == ADDR_CHAN;
    en = s_q.mode[EN_BIT];
    hw = s_q.mode[HW_BIT];
    busy = s_q.st inside {ST_DELAY, ST_SAMPLE, ST_CONV};
    done = 1'b0;
    // Reads return the old result even in the edge that lands a new one
    unique case (bus.addr)
      ADDR_MODE: s_d.rdata = s_q.mode;
      ADDR_CHAN: s_d.rdata = s_q.chan;
      ADDR_RESULT: s_d.rdata = s_q.result;
      ADDR_FLAG: s_d.rdata = {7'h00, s_q.flag};
      default: s_d.rdata = 8'h00;
    endcase
    if (!bus.re) begin
      s_d.rdata = s_q.rdata;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.st = ST_IDLE;
      end
      ST_WAIT: begin
        if (trig_hit) begin
          s_d.st = ST_DELAY;
          s_d.cnt = '0;
        end
      end
      ST_DELAY: begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt + 8'h01 >= tm.delay) begin
          s_d.st = ST_SAMPLE;
          s_d.cnt = '0;
        end
      end
      ST_SAMPLE: begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt + 8'h01 >= tm.sample) begin
          s_d.st = ST_CONV;
          s_d.cnt = '0;
          s_d.bitn = 3'h7;
          s_d.successive_approx_reg = 8'h80;
          // Step rounds down, so a conversion may finish up to 6 periods early
          s_d.step = 8'((tm.total - tm.sample) >> 3);
        end
      end
      ST_CONV: begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt + 8'h01 >= s_q.step) begin
          s_d.cnt = '0;
          s_d.successive_approx_reg[s_q.bitn] = cmp;
          if (s_q.bitn == 3'h0) begin
            done = 1'b1;
          end else begin
            s_d.bitn = s_q.bitn - 3'h1;
            s_d.successive_approx_reg[s_q.bitn - 3'h1] = 1'b1;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Write wins over the end of a conversion
    if (done && !wr_mode && !wr_chan && !STANDBY) begin
      s_d.result = s_d.successive_approx_reg;
      s_d.irq = 1'b1;
      s_d.flag = 1'b1;
      s_d.st = hw ? ST_WAIT : ST_DELAY;
      s_d.cnt = '0;
    end else if (FLAG_CLR) begin
      s_d.flag = 1'b0;
    end
    if (wr_chan) begin
      s_d.chan = {6'h00, bus.wdata[1:0]};
      if (en && busy) begin
        s_d.st = hw ? ST_WAIT : ST_DELAY;
        s_d.cnt = '0;
      end
    end
    if (wr_mode) begin
      s_d.mode = {bus.wdata[7:1], 1'b0};
      // Time code is taken as written; software stops first when it changes it
      if (!bus.wdata[EN_BIT]) begin
        s_d.st = ST_IDLE;
      end else if (bus.wdata[HW_BIT]) begin
        if (busy || !en || s_q.st == ST_IDLE) begin
          s_d.st = ST_WAIT;
        end
      end else if (busy || !en || s_q.st == ST_IDLE || s_q.st == ST_WAIT) begin
        s_d.st = ST_DELAY;
        s_d.cnt = '0;
      end
    end
    tm_nx = adcs_timing(s_d.mode[TIME_LSB +: 3]);
    if (s_d.st != ST_IDLE && !tm_nx.legal) begin
      s_d.st = ST_IDLE;
    end
    if (STANDBY) begin
      s_d.st = ST_IDLE;
      s_d.irq = 1'b0;
    end
    // Status pins are registered copies of the next state, so they leave a flop
    s_d.smp_en = s_d.st == ST_SAMPLE;
    s_d.conv_on = s_d.st == ST_CONV;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '{st: ST_IDLE, mode: MODE_RESET, chan: CHAN_RESET, result: RESULT_RESET,
               successive_approx_reg: 8'h00, bitn: 3'h0, cnt: '0, step: '0, flag: 1'b0, irq: 1'b0,
               rdata: 8'h00, cmp_sync: 3'h0, smp_en: 1'b0, conv_on: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign BUS_RDATA = s_q.rdata;
  assign TAP_CODE = s_q.successive_approx_reg;
  assign CHANNEL_SEL = s_q.chan[1:0];
  assign SAMPLE_EN = s_q.smp_en;
  assign CONV_BUSY = s_q.conv_on;
  assign CONV_END_IRQ = s_q.irq;
  assign CONV_END_FLAG = s_q.flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  idle_when_off_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $past(wr_mode) && !$past(BUS_WDATA[EN_BIT]) |-> s_q.st == ST_IDLE)
    else $error("conversion still running after disable");
  standby_stop_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $past(STANDBY) |-> s_q.st == ST_IDLE && !CONV_END_IRQ)
    else $error("activity during standby");
  irq_result_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CONV_END_IRQ |-> s_q.result == $past(s_d.successive_approx_reg) && s_q.flag)
    else $error("irq without result latch");
  write_wins_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (wr_mode || wr_chan) && !STANDBY |=> !CONV_END_IRQ)
    else $error("completion taken despite register write");
  flag_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.flag && !FLAG_CLR |=> s_q.flag)
    else $error("end flag lost");
  msb_first_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_SAMPLE && s_d.st == ST_CONV |=> s_q.successive_approx_reg == 8'h80 && s_q.bitn == 3'h7)
    else $error("approximation not started at msb");
  hw_idle_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CONV_END_IRQ && hw |-> s_q.st == ST_WAIT)
    else $error("hardware start did not return to wait");
  sw_repeat_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CONV_END_IRQ && !hw |-> s_q.st == ST_DELAY)
    else $error("software start did not repeat");
  trig_ignored_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_CONV && trig_hit && !wr_mode && !wr_chan && !STANDBY && !done |=> s_q.st == ST_CONV)
    else $error("trigger disturbed conversion");
  chan_clean_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_chan |=> s_q.chan[7:2] == 6'h00 && s_q.chan[1:0] == $past(BUS_WDATA[1:0]))
    else $error("channel register wrong");
  irq_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CONV_END_IRQ |=> !CONV_END_IRQ)
    else $error("end pulse longer than one cycle");
  result_hold_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !CONV_END_IRQ |-> $stable(s_q.result))
    else $error("result changed without end pulse");
  flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.flag && FLAG_CLR && !done |=> !s_q.flag)
    else $error("end flag not cleared");
  delay_cnt_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_DELAY |-> s_q.cnt < tm.delay)
    else $error("start delay overrun");
  sample_cnt_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_SAMPLE |-> s_q.cnt < tm.sample)
    else $error("sampling overrun");
  step_cnt_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_CONV |-> s_q.cnt < s_q.step)
    else $error("bit step overrun");
  wait_stay_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_WAIT && !trig_hit && !wr_mode && !STANDBY |=> s_q.st == ST_WAIT)
    else $error("left wait without trigger");
  trig_start_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_WAIT && trig_hit && !wr_mode && !STANDBY |=> s_q.st == ST_DELAY && s_q.cnt == '0)
    else $error("trigger did not start conversion");
  chan_abort_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_chan && en && busy && !STANDBY |=> s_q.st == (hw ? ST_WAIT : ST_DELAY))
    else $error("channel write did not abort");
  mode_layout_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_mode |=> s_q.mode == {$past(BUS_WDATA[7:1]), 1'b0})
    else $error("mode register wrong");
  hw_restart_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_mode && BUS_WDATA[EN_BIT] && BUS_WDATA[HW_BIT] && busy && tm_nx.legal && !STANDBY |=> s_q.st == ST_WAIT)
    else $error("enable rewrite did not discard hardware conversion");
  sw_restart_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_mode && BUS_WDATA[EN_BIT] && !BUS_WDATA[HW_BIT] && busy && tm_nx.legal && !STANDBY
    |=> s_q.st == ST_DELAY && s_q.cnt == '0)
    else $error("enable rewrite did not restart conversion");
  bit_step_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_CONV && s_d.st == ST_CONV && s_q.bitn != 3'h0 && s_q.cnt + 8'h01 >= s_q.step
    |=> s_q.bitn == $past(s_q.bitn) - 3'h1 && s_q.cnt == '0)
    else $error("bit decision out of order");
  idle_stays_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_q.st == ST_IDLE && !wr_mode |=> s_q.st == ST_IDLE)
    else $error("converter woke without mode write");
  en_off_idle_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !en |-> s_q.st == ST_IDLE)
    else $error("activity with enable cleared");
  sw_no_wait_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    en && !hw |-> s_q.st != ST_WAIT)
    else $error("software start waiting for trigger");
  rdata_hold_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !BUS_RE |=> $stable(BUS_RDATA))
    else $error("read data changed without read");
  standby_keep_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    STANDBY |=> $stable(s_q.result))
    else $error("result latched during standby");
endmodule : adcs_sequencer

// ===== testbench/adcs_analog_model.sv
`timescale 1ns/1ps
module adcs_analog_model
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] levels,
  input wire logic [1:0] chan,
  input wire logic sample_en,
  input wire logic [7:0] tap,
  output logic cmp_ge
);
  logic [7:0] held_q = 8'h00;
  // Hold tracks the chosen input only while sampling, so a late level change cannot leak in
  always @(posedge clk) if (sample_en) held_q <= levels[chan*8 +: 8];
  assign cmp_ge = held_q >= tap;
endmodule : adcs_analog_model

// ===== testbench/adcs_sequencer_test.sv
`timescale 1ns/1ps
module adcs_sequencer_test;
  import adcs_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, bus_we = 1'b0, bus_re = 1'b0;
  logic flag_clr = 1'b0, standby = 1'b0, trig = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, rdata, tap;
  logic [1:0] chan, cur_ch = 2'h0;
  logic [31:0] levels = 32'h0, seed = 32'd38020;
  logic cmp_ge, sample_en, busy, irq, flag;
  int n_errors = 0, checks = 0;
  int tot_t[8] = '{144, 120, 96, 0, 72, 60, 48, 0};
  int smp_t[8] = '{20, 16, 12, 0, 10, 8, 6, 0};
  adcs_sequencer u_dut(.CLK_SYS(clk_sys), .ARST_N(arst_n), .BUS_WE(bus_we), .BUS_RE(bus_re),
    .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_RDATA(rdata), .FLAG_CLR(flag_clr),
    .STANDBY(standby), .TRIGGER_PIN(trig), .CMP_GE(cmp_ge), .TAP_CODE(tap), .CHANNEL_SEL(chan),
    .SAMPLE_EN(sample_en), .CONV_BUSY(busy), .CONV_END_IRQ(irq), .CONV_END_FLAG(flag));
  adcs_analog_model u_ana(.clk(clk_sys), .levels(levels), .chan(chan), .sample_en(sample_en),
    .tap(tap), .cmp_ge(cmp_ge));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk8
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_re <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_re <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic tog();
    @(posedge clk_sys);
    trig <= ~trig;
  endtask : tog
  // Bounded wait: 0 sampling starts, 1 end pulse, 2 sampling ends
  task automatic wait_on(input int which, input int bound, output int cnt);
    for (cnt = 1; cnt <= bound; cnt++) begin
      @(posedge clk_sys);
      #1;
      if (which == 0 ? sample_en === 1'b1 : which == 1 ? irq === 1'b1 : sample_en === 1'b0) return;
    end
    n_errors++;
    $display("wrong value at %0t: wait %0d timed out", $time, which);
    report_and_stop();
  endtask : wait_on
  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(posedge clk_sys);
      #1 chk8({5'h0, busy, sample_en, irq}, 8'h00, "idle");
    end
  endtask : quiet
  task automatic conv(input int code, input int lo, input int hi);
    int d, s, c;
    logic [7:0] r;
    wait_on(0, 40, d);
    chk_rng(d, lo, hi, "start delay");
    chk8({6'h0, chan}, {6'h0, cur_ch}, "channel");
    wait_on(2, 40, s);
    chk_rng(s, smp_t[code], smp_t[code], "sampling");
    wait_on(1, 200, c);
    chk_rng(s + c, tot_t[code] - 8, tot_t[code] + 2, "conversion");
    rd(ADDR_RESULT, r);
    chk8(r, levels[cur_ch*8 +: 8], "result");
    chk8({7'h0, flag}, 8'h01, "end flag");
  endtask : conv
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    int n;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADDR_MODE, r);
    chk8(r, 8'h00, "mode reset");
    rd(ADDR_CHAN, r);
    chk8(r, 8'h00, "chan reset");
    rd(ADDR_RESULT, r);
    chk8(r, 8'h00, "result reset");
    rd(16'hff9e, r);
    chk8(r, 8'h00, "unmapped");
    for (int k = 0; k < 7; k++) begin
      if (k == 3) continue;
      levels <= rnd();
      cur_ch = 2'(rnd());
      wr(ADDR_CHAN, {6'h0, cur_ch});
      rd(ADDR_CHAN, r);
      chk8(r, {6'h0, cur_ch}, "chan");
      wr(ADDR_MODE, {2'b10, 3'(k), 3'b000});
      conv(k, k < 4 ? 7 : 4, k < 4 ? 10 : 7);
      wait_on(0, 20, n);
      repeat (4) @(posedge clk_sys);
      wr(ADDR_MODE, 8'h00);
      quiet(tot_t[k] + 20);
    end
    wr(ADDR_CHAN, 8'h00);
    #1 chk8({7'h0, flag}, 8'h01, "flag kept");
    rd(ADDR_FLAG, r);
    chk8(r, 8'h01, "flag read");
    @(posedge clk_sys);
    flag_clr <= 1'b1;
    @(posedge clk_sys);
    flag_clr <= 1'b0;
    @(posedge clk_sys);
    #1 chk8({7'h0, flag}, 8'h00, "flag clear");
    rd(ADDR_FLAG, r);
    chk8(r, 8'h00, "flag read clear");
    cur_ch = 2'h0;
    wr(ADDR_MODE, 8'h80);
    wait_on(1, 300, n);
    wait_on(0, 20, n);
    wait_on(2, 40, n);
    cur_ch = 2'h2;
    wr(ADDR_CHAN, 8'h02);
    conv(0, 1, 12);
    wait_on(0, 40, n);
    wait_on(2, 40, n);
    wr(ADDR_MODE, 8'h80);
    conv(0, 1, 12);
    wait_on(0, 40, n);
    @(posedge clk_sys);
    standby <= 1'b1;
    quiet(200);
    wr(ADDR_MODE, 8'h00);
    standby <= 1'b0;
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_MODE, {2'b11, 3'b000, 2'(e), 1'b0});
      for (int t = 0; t < 2; t++) begin
        tog();
        if (e[1 - t]) conv(0, 1, 20);
        quiet(160);
      end
    end
    tog();
    wait_on(0, 20, n);
    tog();
    wait_on(1, 200, n);
    quiet(160);
    tog();
    wait_on(0, 20, n);
    wr(ADDR_CHAN, 8'h02);
    quiet(160);
    tog();
    conv(0, 1, 20);
    tog();
    wait_on(0, 20, n);
    wr(ADDR_MODE, 8'hc6);
    quiet(160);
    tog();
    conv(0, 1, 20);
    report_and_stop();
  end
endmodule : adcs_sequencer_test
